// ### logic/bppc_pkg.sv
// ==========================================================================
// shared constants and types for the pack protection control block
package bppc_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_OUT_CTL = 8'h04;
  localparam logic [7:0] OFS_OL_LEVEL = 8'h08;
  localparam logic [7:0] OFS_OL_DELAY = 8'h0C;
  localparam logic [7:0] OFS_SC_CHG = 8'h10;
  localparam logic [7:0] OFS_SC_DSG = 8'h14;
  localparam logic [7:0] OFS_CELL_SEL = 8'h18;
  localparam logic [7:0] OFS_FUNC_CTL = 8'h1C;

  // ==========================================================================
  // field positions
  localparam int ST_SC_CHG = 0;
  localparam int ST_SC_DSG = 1;
  localparam int ST_OL = 2;
  localparam int ST_WDF = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_NORMAL = 5;
  localparam int OC_LATCH_CLR = 0;
  localparam int OC_DSG_EN = 1;
  localparam int OC_CHG_EN = 2;
  localparam int OC_ZV_EN = 3;
  localparam int FC_SLEEP_REQ = 0;
  localparam int FC_THERMISTOR_BIAS_OUT_EN = 5;

  // ==========================================================================
  // reset values
  localparam logic [4:0] OL_LEVEL_RST = 5'h00;
  localparam logic [3:0] OL_DELAY_RST = 4'h0;
  localparam logic [7:0] SC_RST = 8'h00;
  localparam logic [3:0] OUT_CTL_RST = 4'h0;
  localparam logic [3:0] CELL_SEL_RST = 4'h0;
  localparam logic [5:0] FUNC_CTL_RST = 6'h00;

  // ==========================================================================
  // level codes: value = base + code * step (millivolts)
  localparam int OL_BASE_MV = 50;
  localparam int OL_STEP_MV = 5;
  localparam int OL_HYST_MV = 10;
  localparam int SC_BASE_MV = 100;
  localparam int SC_STEP_MV = 25;
  localparam int SC_HYST_MV = 50;

  // ==========================================================================
  // delays in watchdog clock edges (one edge per unit of each step)
  localparam int OL_DLY_MIN_MS = 1;
  localparam int OL_DLY_STEP_MS = 2;
  localparam int SC_DLY_STEP_US = 61;

  // ==========================================================================
  // watchdog timing, counted in pclk cycles at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int WD_GAP_US = 100;
  localparam int WD_GAP_CYC = WD_GAP_US * CLK_MHZ;
  localparam int WD_START_MS = 700;
  localparam int WD_START_CYC = WD_START_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // supply monitor levels and fet drive bundle
  typedef struct packed {
    logic reg_low;
    logic reg_high;
  } bppc_supply_t;

  typedef struct packed {
    logic charge;
    logic discharge;
    logic zero_volt;
  } bppc_fet_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAIT,
    ST_RUN
  } bppc_mode_t;

endpackage : bppc_pkg

// ### logic/bppc_top.sv
// Behaviour
// - regulator below lower threshold: all fet drives and functions off
// - regulator above upper threshold after start-up: enter normal mode
// - initial charge drive follows zero-volt strap level
// - overload level register selects 50..205 mV in 5 mV codes
// - overload level resets to lowest; comparator uses 10 mV hysteresis
// - short-circuit fields select 100..475 mV in 25 mV codes
// - short-circuit levels reset to lowest; comparator uses 50 mV hysteresis
// - separate short-circuit level and delay for charge and discharge
// - overload delay defaults to 1 ms, programmable to 31 ms in 2 ms
// - short-circuit delay defaults 0, to 915 us in 61 us, per direction
// - fault turns fets off only after blanking delay with condition present
// - fault turns fets off and sets one of four status bits
// - status bit set and alert asserted together
// - fault latched until latch-clear set then reset
// - cleared latch with persisting fault re-enters protection
// - cell select low two bits choose monitored cell
// - cell select next two bits choose monitor mode
// - watchdog clock times delays and is watched for loss
// - sleep input high or open enters sleep
// - alert output driven low on status changes
// - no watchdog clock within 700 ms of start: all fets off
// - watchdog gap of 100 us: fets off, flag latched until latch-clear
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module bppc_top #(
  parameter int WD_START_CYC = bppc_pkg::WD_START_CYC,
  parameter int WD_GAP_CYC = bppc_pkg::WD_GAP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog monitor and comparator inputs (asynchronous)
  input wire bppc_pkg::bppc_supply_t supply_in,
  input wire logic [9:0] sense_mv_in,
  input wire logic sense_charge_dir_in,
  input wire logic zero_volt_strap,
  input wire logic sleep_in,
  input wire logic watchdog_clock_in,
  // fet drives and control outputs
  output bppc_pkg::bppc_fet_t fet_drive,
  output logic thermistor_bias_out,
  output logic regulator_en,
  output logic [1:0] cell_index,
  output logic [1:0] monitor_mode,
  // open-drain alert: output enable low while driving low
  output logic alert_out_n,
  output logic alert_oe_n
);

  // ==========================================================================
  // input synchronisers
  logic [1:0] sup_lo_s, sup_hi_s, strap_s, sleep_s, wdi_s, dir_s;
  logic [9:0] sense_s1_q, sense_q;
  logic wdi_prev_q;

  // two flops on every async input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_lo_s <= 2'h3;
      sup_hi_s <= 2'h0;
      strap_s <= 2'h0;
      sleep_s <= 2'h3;
      wdi_s <= 2'h0;
      dir_s <= 2'h0;
      sense_s1_q <= 10'h000;
      sense_q <= 10'h000;
      wdi_prev_q <= 1'b0;
    end
    else
    begin
      sup_lo_s <= {sup_lo_s[0], supply_in.reg_low};
      sup_hi_s <= {sup_hi_s[0], supply_in.reg_high};
      strap_s <= {strap_s[0], zero_volt_strap};
      sleep_s <= {sleep_s[0], sleep_in};
      wdi_s <= {wdi_s[0], watchdog_clock_in};
      dir_s <= {dir_s[0], sense_charge_dir_in};
      sense_s1_q <= sense_mv_in;
      sense_q <= sense_s1_q;
      wdi_prev_q <= wdi_s[1];
    end
  end

  // synchronised levels and watchdog rising edge
  logic wd_edge, reg_low, reg_high, strap, asleep, chg_dir;
  assign wd_edge = wdi_s[1] & ~wdi_prev_q;
  assign reg_low = sup_lo_s[1];
  assign reg_high = sup_hi_s[1];
  assign strap = strap_s[1];
  assign chg_dir = dir_s[1];

  // ==========================================================================
  // registers
  logic [4:0] ol_level_q;
  logic [3:0] ol_delay_q;
  logic [7:0] sc_chg_q, sc_dsg_q;
  logic [3:0] out_ctl_q, cell_sel_q;
  logic [5:0] func_ctl_q;
  logic [3:0] status_q;
  logic [5:0] status_word;
  // apb access strobes
  logic wr, rd;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign asleep = sleep_s[1] | func_ctl_q[bppc_pkg::FC_SLEEP_REQ];

  // mode machine
  bppc_pkg::bppc_mode_t mode_q;
  logic [31:0] wd_cnt_q;
  logic wd_fault;

  // ==========================================================================
  // mode: off until regulator high, then watch for host clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= bppc_pkg::ST_OFF;
    else if (reg_low)
      mode_q <= bppc_pkg::ST_OFF;
    else
    begin
      unique case (mode_q)
        bppc_pkg::ST_OFF: if (reg_high) mode_q <= bppc_pkg::ST_WAIT;
        bppc_pkg::ST_WAIT: if (wd_edge) mode_q <= bppc_pkg::ST_RUN;
        bppc_pkg::ST_RUN: ;
        default: mode_q <= bppc_pkg::ST_OFF;
      endcase
    end
  end

  // watchdog gap and start-up timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_cnt_q <= 32'h0;
    else if (wd_edge || mode_q == bppc_pkg::ST_OFF || asleep)
      wd_cnt_q <= 32'h0;
    else if (!wd_fault)
      wd_cnt_q <= wd_cnt_q + 32'h1;
  end

  assign wd_fault = !asleep &&
    ((mode_q == bppc_pkg::ST_WAIT && wd_cnt_q >= 32'(WD_START_CYC)) ||
     (mode_q == bppc_pkg::ST_RUN && wd_cnt_q >= 32'(WD_GAP_CYC)));

  // ==========================================================================
  // comparators with hysteresis
  // trip levels from the programmed codes
  logic [9:0] ol_trip_mv, sc_chg_mv, sc_dsg_mv;
  assign ol_trip_mv = 10'(bppc_pkg::OL_BASE_MV) + 10'(ol_level_q) * 10'(bppc_pkg::OL_STEP_MV);
  assign sc_chg_mv = 10'(bppc_pkg::SC_BASE_MV) + 10'(sc_chg_q[3:0]) * 10'(bppc_pkg::SC_STEP_MV);
  assign sc_dsg_mv = 10'(bppc_pkg::SC_BASE_MV) + 10'(sc_dsg_q[3:0]) * 10'(bppc_pkg::SC_STEP_MV);

  logic ol_cond_q, scc_cond_q, scd_cond_q;

  // trip above level, release below level minus hysteresis
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_cond_q <= 1'b0;
      scc_cond_q <= 1'b0;
      scd_cond_q <= 1'b0;
    end
    else
    begin
      ol_cond_q <= !chg_dir && (ol_cond_q ? 11'(sense_q) + 11'(bppc_pkg::OL_HYST_MV) >= 11'(ol_trip_mv)
                                          : sense_q >= ol_trip_mv);
      scc_cond_q <= chg_dir && (scc_cond_q ? 11'(sense_q) + 11'(bppc_pkg::SC_HYST_MV) >= 11'(sc_chg_mv)
                                           : sense_q >= sc_chg_mv);
      scd_cond_q <= !chg_dir && (scd_cond_q ? 11'(sense_q) + 11'(bppc_pkg::SC_HYST_MV) >= 11'(sc_dsg_mv)
                                            : sense_q >= sc_dsg_mv);
    end
  end

  // ==========================================================================
  // blanking delays in watchdog edges
  logic [15:0] ol_need, scc_need, scd_need;
  logic [15:0] ol_cnt_q, scc_cnt_q, scd_cnt_q;
  assign ol_need = 16'(bppc_pkg::OL_DLY_MIN_MS) + 16'(ol_delay_q) * 16'(bppc_pkg::OL_DLY_STEP_MS);
  assign scc_need = 16'(sc_chg_q[7:4]) * 16'(bppc_pkg::SC_DLY_STEP_US);
  assign scd_need = 16'(sc_dsg_q[7:4]) * 16'(bppc_pkg::SC_DLY_STEP_US);

  // trip once the blanking count is reached
  logic ol_trip, scc_trip, scd_trip;
  assign ol_trip = ol_cond_q && ol_cnt_q >= ol_need;
  assign scc_trip = scc_cond_q && scc_cnt_q >= scc_need;
  assign scd_trip = scd_cond_q && scd_cnt_q >= scd_need;

  // count edges while condition holds, restart when it drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_cnt_q <= 16'h0;
      scc_cnt_q <= 16'h0;
      scd_cnt_q <= 16'h0;
    end
    else
    begin
      ol_cnt_q <= !ol_cond_q ? 16'h0 : (wd_edge && !ol_trip) ? ol_cnt_q + 16'h1 : ol_cnt_q;
      scc_cnt_q <= !scc_cond_q ? 16'h0 : (wd_edge && !scc_trip) ? scc_cnt_q + 16'h1 : scc_cnt_q;
      scd_cnt_q <= !scd_cond_q ? 16'h0 : (wd_edge && !scd_trip) ? scd_cnt_q + 16'h1 : scd_cnt_q;
    end
  end

  // ==========================================================================
  // status latch; set wins over clear
  logic clr_q, clr_fall, active;
  assign active = mode_q != bppc_pkg::ST_OFF && !asleep;
  assign clr_fall = clr_q && wr && paddr == bppc_pkg::OFS_OUT_CTL &&
                    !pwdata[bppc_pkg::OC_LATCH_CLR];
  logic [3:0] events;
  assign events = active ? {wd_fault, ol_trip, scd_trip, scc_trip} : 4'h0;
  logic sleep_prev_q, alert_q, strap_cap_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q[3:0] <= 4'h0;
      clr_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == bppc_pkg::OFS_OUT_CTL)
        clr_q <= pwdata[bppc_pkg::OC_LATCH_CLR];
      status_q[3:0] <= (clr_fall ? 4'h0 : status_q[3:0]) | events;
    end
  end

  // alert: low on fault or sleep change, released by read after clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alert_q <= 1'b0;
      sleep_prev_q <= 1'b1;
    end
    else
    begin
      sleep_prev_q <= asleep;
      if (|events || sleep_prev_q != asleep)
        alert_q <= 1'b1;
      else if (rd && paddr == bppc_pkg::OFS_STATUS && !clr_q && status_q[3:0] == 4'h0)
        alert_q <= 1'b0;
    end
  end

  // readable status: latched faults plus live sleep and normal flags
  always_comb
  begin
    status_word = {2'h0, status_q};
    status_word[bppc_pkg::ST_SLEEP] = asleep;
    status_word[bppc_pkg::ST_NORMAL] = mode_q == bppc_pkg::ST_RUN;
  end

  // ==========================================================================
  // strap sampled while off, held from leaving the off state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strap_cap_q <= 1'b0;
    else if (mode_q == bppc_pkg::ST_OFF)
      strap_cap_q <= strap;
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_level_q <= bppc_pkg::OL_LEVEL_RST;
      ol_delay_q <= bppc_pkg::OL_DELAY_RST;
      sc_chg_q <= bppc_pkg::SC_RST;
      sc_dsg_q <= bppc_pkg::SC_RST;
      out_ctl_q <= bppc_pkg::OUT_CTL_RST;
      cell_sel_q <= bppc_pkg::CELL_SEL_RST;
      func_ctl_q <= bppc_pkg::FUNC_CTL_RST;
    end
    else if (wr)
    begin
      unique case (paddr)
        bppc_pkg::OFS_OL_LEVEL: ol_level_q <= pwdata[4:0];
        bppc_pkg::OFS_OL_DELAY: ol_delay_q <= pwdata[3:0];
        bppc_pkg::OFS_SC_CHG: sc_chg_q <= pwdata[7:0];
        bppc_pkg::OFS_SC_DSG: sc_dsg_q <= pwdata[7:0];
        bppc_pkg::OFS_OUT_CTL: out_ctl_q <= pwdata[3:0];
        bppc_pkg::OFS_CELL_SEL: cell_sel_q <= pwdata[3:0];
        bppc_pkg::OFS_FUNC_CTL: func_ctl_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // fet drives: off on any latched fault, sleep or low supply
  logic fets_ok, chg_on;
  assign fets_ok = mode_q == bppc_pkg::ST_RUN && !asleep && status_q[3:0] == 4'h0 && ~|events;
  assign chg_on = out_ctl_q[bppc_pkg::OC_CHG_EN] | strap_cap_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fet_drive <= '0;
      thermistor_bias_out <= 1'b0;
      regulator_en <= 1'b0;
      cell_index <= 2'h0;
      monitor_mode <= 2'h0;
      alert_out_n <= 1'b1;
      alert_oe_n <= 1'b1;
      prdata <= 32'h0;
    end
    else
    begin
      fet_drive.charge <= fets_ok && chg_on;
      fet_drive.discharge <= fets_ok && out_ctl_q[bppc_pkg::OC_DSG_EN];
      fet_drive.zero_volt <= fets_ok && out_ctl_q[bppc_pkg::OC_ZV_EN];
      thermistor_bias_out <= !reg_low && func_ctl_q[bppc_pkg::FC_THERMISTOR_BIAS_OUT_EN];
      regulator_en <= !reg_low && mode_q != bppc_pkg::ST_OFF;
      cell_index <= cell_sel_q[1:0];
      monitor_mode <= cell_sel_q[3:2];
      alert_out_n <= 1'b0;
      alert_oe_n <= ~alert_q;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          bppc_pkg::OFS_STATUS: prdata <= {26'h0, status_word};
          bppc_pkg::OFS_OUT_CTL: prdata <= {28'h0, out_ctl_q[3:1], clr_q};
          bppc_pkg::OFS_OL_LEVEL: prdata <= {27'h0, ol_level_q};
          bppc_pkg::OFS_OL_DELAY: prdata <= {28'h0, ol_delay_q};
          bppc_pkg::OFS_SC_CHG: prdata <= {24'h0, sc_chg_q};
          bppc_pkg::OFS_SC_DSG: prdata <= {24'h0, sc_dsg_q};
          bppc_pkg::OFS_CELL_SEL: prdata <= {28'h0, cell_sel_q};
          bppc_pkg::OFS_FUNC_CTL: prdata <= {26'h0, func_ctl_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // apb answers in the first access cycle; unmapped gives slverr
  logic mapped;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= bppc_pkg::OFS_FUNC_CTL;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

endmodule : bppc_top

// ### sim/bppc_checker.sv
`timescale 1ns/1ps
// ==========================================================================
// port checker
module bppc_checker #(
  parameter int WD_GAP_CYC = 200
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // monitored inputs
  input wire bppc_pkg::bppc_supply_t supply_in,
  input wire logic sleep_in,
  input wire logic watchdog_clock_in,
  // outputs
  input wire bppc_pkg::bppc_fet_t fet_drive,
  input wire logic thermistor_bias_out,
  input wire logic regulator_en,
  input wire logic [1:0] cell_index,
  input wire logic [1:0] monitor_mode,
  input wire logic alert_oe_n
);
  logic wd_q;
  logic seen_q;
  logic st_rd_q;
  int gap_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // cycles since the last watchdog level change, and status reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 0;
      st_rd_q <= 1'b0;
    end
    else
    begin
      wd_q <= watchdog_clock_in;
      seen_q <= seen_q | (watchdog_clock_in != wd_q);
      gap_q <= (watchdog_clock_in != wd_q) ? 0 : gap_q + 1;
      st_rd_q <= psel && penable && pready && !pwrite && paddr == bppc_pkg::OFS_STATUS;
    end
  end

  a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
    else $error("no error on unmapped address");
  a_cell_sel_out: assert property (psel && penable && pready && pwrite && paddr == bppc_pkg::OFS_CELL_SEL
    |-> ##2 {monitor_mode, cell_index} == $past(pwdata[3:0], 2))
    else $error("cell select outputs wrong");
  a_lowsup_fets: assert property (supply_in.reg_low [*5] |-> fet_drive == 3'h0)
    else $error("fet drive on with regulator low");
  a_lowsup_func: assert property (supply_in.reg_low [*5] |-> !regulator_en && !thermistor_bias_out)
    else $error("functions on with regulator low");
  a_sleep_fets: assert property (sleep_in [*5] |-> fet_drive == 3'h0)
    else $error("fet drive on in sleep");
  a_wd_gap_off: assert property (seen_q && gap_q > WD_GAP_CYC + 8 |-> fet_drive == 3'h0)
    else $error("fet drive on after watchdog gap");
  a_alert_release: assert property ($rose(alert_oe_n) |-> st_rd_q || $past(st_rd_q))
    else $error("alert released without status read");

  c_alert: cover property ($fell(alert_oe_n));
  c_dsg_off: cover property ($fell(fet_drive.discharge));
  c_slverr: cover property (pslverr);
endmodule : bppc_checker

bind bppc_top bppc_checker #(.WD_GAP_CYC(WD_GAP_CYC)) bppc_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .supply_in(supply_in),
  .sleep_in(sleep_in), .watchdog_clock_in(watchdog_clock_in), .fet_drive(fet_drive),
  .thermistor_bias_out(thermistor_bias_out), .regulator_en(regulator_en),
  .cell_index(cell_index), .monitor_mode(monitor_mode), .alert_oe_n(alert_oe_n)
);

// ### sim/bppc_top_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench
module bppc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bppc_pkg::bppc_supply_t supply_in;
  logic [9:0] sense_mv_in;
  logic sense_charge_dir_in, zero_volt_strap, sleep_in, watchdog_clock_in, wd_run;
  bppc_pkg::bppc_fet_t fet_drive;
  logic thermistor_bias_out, regulator_en, alert_out_n, alert_oe_n;
  logic [1:0] cell_index, monitor_mode;
  int failures;
  int n_tests;

  bppc_top #(.WD_START_CYC(2000), .WD_GAP_CYC(200)) bppc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_in(supply_in), .sense_mv_in(sense_mv_in), .sense_charge_dir_in(sense_charge_dir_in),
    .zero_volt_strap(zero_volt_strap), .sleep_in(sleep_in), .watchdog_clock_in(watchdog_clock_in),
    .fet_drive(fet_drive), .thermistor_bias_out(thermistor_bias_out), .regulator_en(regulator_en),
    .cell_index(cell_index), .monitor_mode(monitor_mode), .alert_out_n(alert_out_n),
    .alert_oe_n(alert_oe_n)
  );
  bppc_wd_host bppc_wd_host_inst (.run(wd_run), .watchdog_clock_in(watchdog_clock_in));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc

  // wait a bounded time for the fet drives, then compare
  task automatic fets(input string what, input bppc_pkg::bppc_fet_t exp, input int n);
    for (int i = 0; i < n && fet_drive !== exp; i++)
      @(posedge pclk);
    chk(what, 32'(exp), 32'(fet_drive));
  endtask : fets

  // pulse latch clear, read status, alert must release
  task automatic clr();
    wr(bppc_pkg::OFS_OUT_CTL, 32'h7);
    wr(bppc_pkg::OFS_OUT_CTL, 32'h6);
    rdc("status cleared", bppc_pkg::OFS_STATUS, 32'h20);
    repeat (2) @(posedge pclk);
    chk("alert released", 32'h1, 32'(alert_oe_n));
    fets("fets back", 3'h6, 10);
  endtask : clr

  task automatic t_start();
    fets("strap charge", 3'h4, 20);
    chk("regulator on", 32'h1, 32'(regulator_en));
    rdc("status normal", bppc_pkg::OFS_STATUS, 32'h20);
    for (int a = 4; a < 32; a += 4)
      rdc("reset value", 8'(a), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    wr(bppc_pkg::OFS_OUT_CTL, 32'h6);
    fets("host enable", 3'h6, 10);
    chk("alert pin level", 32'h0, 32'(alert_out_n));
    clr();
  endtask : t_start

  task automatic t_cell();
    logic [3:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = 4'(i * 13);
      wr(bppc_pkg::OFS_CELL_SEL, 32'(v));
      repeat (2) @(posedge pclk);
      chk("cell", 32'(v[1:0]), 32'(cell_index));
      chk("mode", 32'(v[3:2]), 32'(monitor_mode));
    end
  endtask : t_cell

  // short circuit in one direction: below level holds, above trips after delay
  task automatic t_sc(input logic dir, input logic [7:0] a, input logic [7:0] code, input int bitn,
                      input int below, input int above, input int hold);
    wr(bppc_pkg::OFS_OL_LEVEL, 32'h1F); // overload level above the discharge test currents
    wr(a, 32'(code));
    sense_charge_dir_in <= dir;
    sense_mv_in <= 10'(below);
    repeat (20) @(posedge pclk);
    fets("below level", 3'h6, 0);
    sense_mv_in <= 10'(above);
    repeat (hold) @(posedge pclk);
    fets("blanking", 3'h6, 0);
    fets("trip", 3'h0, 1000);
    rdc("fault status", bppc_pkg::OFS_STATUS, 32'h20 | (32'h1 << bitn));
    chk("alert set", 32'h0, 32'(alert_oe_n));
    sense_mv_in <= 10'h000;
    clr();
  endtask : t_sc

  task automatic t_ol();
    wr(bppc_pkg::OFS_SC_DSG, 32'h0F);
    wr(bppc_pkg::OFS_OL_LEVEL, 32'h0A);
    wr(bppc_pkg::OFS_OL_DELAY, 32'h1);
    sense_charge_dir_in <= 1'b0;
    sense_mv_in <= 10'd105;
    repeat (10) @(posedge pclk);
    fets("ol blanking", 3'h6, 0);
    fets("ol trip", 3'h0, 100);
    rdc("ol status", bppc_pkg::OFS_STATUS, 32'h24);
    wr(bppc_pkg::OFS_OUT_CTL, 32'h7);
    wr(bppc_pkg::OFS_OUT_CTL, 32'h6);
    fets("retrip", 3'h0, 100);
    rdc("retrip status", bppc_pkg::OFS_STATUS, 32'h24);
    sense_mv_in <= 10'h000;
    clr();
  endtask : t_ol

  task automatic t_wd();
    wd_run <= 1'b0;
    fets("wd gap", 3'h0, 400);
    wd_run <= 1'b1;
    repeat (40) @(posedge pclk);
    rdc("wd flag", bppc_pkg::OFS_STATUS, 32'h28);
    clr();
  endtask : t_wd

  task automatic t_power();
    wr(bppc_pkg::OFS_FUNC_CTL, 32'h21);
    fets("sleep request", 3'h0, 10);
    wr(bppc_pkg::OFS_FUNC_CTL, 32'h20);
    repeat (2) @(posedge pclk);
    chk("bias on", 32'h1, 32'(thermistor_bias_out));
    sleep_in <= 1'b1;
    fets("sleep", 3'h0, 10);
    rdc("sleep status", bppc_pkg::OFS_STATUS, 32'h30);
    sleep_in <= 1'b0;
    repeat (5) @(posedge pclk);
    clr();
    supply_in <= '{reg_low: 1'b1, reg_high: 1'b0};
    fets("low supply", 3'h0, 10);
    chk("regulator off", 32'h0, 32'(regulator_en));
    chk("bias off", 32'h0, 32'(thermistor_bias_out));
  endtask : t_power

  // reset again with no host clock: start-up window runs out
  task automatic t_boot();
    wd_run <= 1'b0;
    supply_in <= '{reg_low: 1'b0, reg_high: 1'b1};
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2100) @(posedge pclk);
    rdc("start-up wd flag", bppc_pkg::OFS_STATUS, 32'h08);
    fets("start-up fets", 3'h0, 0);
  endtask : t_boot

  // watchdog against a hang
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    failures = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    supply_in = '{reg_low: 1'b0, reg_high: 1'b1};
    sense_mv_in = 10'h000;
    sense_charge_dir_in = 1'b0;
    zero_volt_strap = 1'b1;
    sleep_in = 1'b0;
    wd_run = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_start();
    t_cell();
    t_sc(1'b0, bppc_pkg::OFS_SC_DSG, 8'h12, 1, 140, 160, 400);
    t_sc(1'b1, bppc_pkg::OFS_SC_CHG, 8'h08, 0, 290, 320, 0);
    t_ol();
    t_wd();
    t_power();
    t_boot();
    tally_and_finish();
  end
endmodule : bppc_top_tb

// ### sim/bppc_wd_host.sv
`timescale 1ns/1ps
// ==========================================================================
// host side: free-running watchdog clock source
module bppc_wd_host (
  // control from the bench
  input wire logic run,
  // clock to the device
  output logic watchdog_clock_in
);
  // 125 ns period, phase unrelated to pclk, holds its level while halted
  initial
  begin
    watchdog_clock_in = 1'b0;
    #3.3;
    forever
    begin
      #62.5;
      if (run) watchdog_clock_in = ~watchdog_clock_in;
    end
  end
endmodule : bppc_wd_host
